// ===== power_monitor_conv_setup.sv
// setup registers and conversion sequencer of the power monitor converter
`timescale 1ns/100ps
module power_monitor_conv_setup #(
	parameter int         US_CYC       = pwrmon_pkg::CLK_MHZ,
	parameter int         DLY_STEP_CYC = pwrmon_pkg::DLY_STEP_CYC,
	parameter logic [6:0] DEV_ADDR     = 7'h40
) (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_arst_n,
	// serial pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	// converter control
	output logic            o_shunt_range,
	output logic            o_conv_active,
	output logic [2:0]      o_conv_chan,
	output logic            o_result_upd,
	output logic [2:0]      o_result_chan
);
	import pwrmon_pkg::*;

	typedef struct packed {
		logic [7:0]    dly;
		logic          range;
		logic [15:0]   conv;
		logic          pend;
		seq_state_type st;
		logic [31:0]   cnt;
		logic [10:0]   samp;
		logic [2:0]    rem;
		logic [2:0]    chan;
		logic          upd;
		logic [2:0]    upd_chan;
	} core_type;

	// pend set at reset so the default continuous mode starts on its own
	localparam core_type CORE_RST = '{dly: DEV_SETUP_RST[13:6], range: DEV_SETUP_RST[4],
		conv: CONV_SETUP_RST, pend: 1'b1, st: SQ_IDLE, default: '0};

	core_type    s;
	core_type    nxt_s;
	logic [15:0] dev_word;
	regbus_if    bus ();

	i2c_reg_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.i_scl     (i_scl),
		.i_sda     (i_sda),
		.o_sda_oe  (o_sda_oe),
		.bus       (bus.slave_end)
	);

	// cycles for one sample of a one-hot channel
	function automatic logic [31:0] ch_cyc(input logic [15:0] cv, input logic [2:0] ch);
		logic [2:0] code;
		code = ch[0] ? cv[BUS_CT_LSB +: 3] : ch[1] ? cv[SHUNT_CT_LSB +: 3] : cv[TEMP_CT_LSB +: 3];
		ch_cyc = 32'(conv_us(code)) * 32'(US_CYC);
	endfunction : ch_cyc

	// start the lowest enabled channel of mask m
	function automatic core_type begin_set(input core_type c, input logic [2:0] m);
		core_type   r;
		logic [2:0] first;
		r       = c;
		first   = m & (~m + 3'h1);
		r.rem   = m;
		r.chan  = first;
		r.st    = SQ_CONV;
		r.cnt   = ch_cyc(c.conv, first) - 32'h1;
		r.samp  = avg_n(c.conv[AVG_LSB +: 3]) - 11'h1;
		begin_set = r;
	endfunction : begin_set

	always_comb
	begin
		nxt_s     = s;
		nxt_s.upd = 1'b0;
		unique case (s.st)
			SQ_IDLE: ;
			SQ_WAIT:
				if (s.cnt == 32'h0)
					nxt_s = begin_set(s, s.conv[MODE_LSB +: 3]);
				else
					nxt_s.cnt = s.cnt - 32'h1;
			SQ_CONV:
				if (s.cnt != 32'h0)
					nxt_s.cnt = s.cnt - 32'h1;
				else if (s.samp != 11'h0)
				begin
					// results wait until the last averaged sample
					nxt_s.samp = s.samp - 11'h1;
					nxt_s.cnt  = ch_cyc(s.conv, s.chan) - 32'h1;
				end
				else
				begin
					nxt_s.upd      = 1'b1;
					nxt_s.upd_chan = s.chan;
					if ((s.rem & ~s.chan) != 3'h0)
						nxt_s = begin_set(nxt_s, s.rem & ~s.chan);
					else if (s.conv[MODE_CONT_BIT])
						nxt_s = begin_set(nxt_s, s.conv[MODE_LSB +: 3]);
					else
					begin
						nxt_s.st   = SQ_IDLE;
						nxt_s.rem  = 3'h0;
						nxt_s.chan = 3'h0;
					end
				end
			default: nxt_s.st = SQ_IDLE;
		endcase
		// a fresh mode restarts the sequence, honouring the start delay
		if (s.pend)
		begin
			nxt_s.pend = 1'b0;
			nxt_s.rem  = 3'h0;
			nxt_s.chan = 3'h0;
			if (s.conv[MODE_LSB +: 3] == 3'h0)
				nxt_s.st = SQ_IDLE;
			else if (s.dly == 8'h0)
				nxt_s = begin_set(nxt_s, s.conv[MODE_LSB +: 3]);
			else
			begin
				nxt_s.st  = SQ_WAIT;
				nxt_s.cnt = 32'(s.dly) * 32'(DLY_STEP_CYC) - 32'h1;
			end
		end
		if (bus.wr_stb && bus.ptr == PTR_DEV_SETUP)
		begin
			if (bus.wdata[DEV_SWRST_BIT])
				nxt_s = CORE_RST;
			else
			begin
				nxt_s.dly   = bus.wdata[DEV_DLY_LSB +: 8];
				nxt_s.range = bus.wdata[DEV_RANGE_BIT];
			end
		end
		else if (bus.wr_stb && bus.ptr == PTR_CONV_SETUP)
		begin
			nxt_s.conv = bus.wdata;
			nxt_s.pend = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= CORE_RST;
		else
			s <= nxt_s;
	end

	// reserved and reset bits are never stored, so they read zero
	assign dev_word  = {2'b00, s.dly, 1'b0, s.range, 4'h0};
	assign bus.rdata = (bus.ptr == PTR_DEV_SETUP)  ? dev_word :
	                   (bus.ptr == PTR_CONV_SETUP) ? s.conv : 16'h0000;

	assign o_sda         = 1'b0;
	assign o_shunt_range = s.range;
	assign o_conv_active = s.st[2];
	assign o_conv_chan   = s.chan;
	assign o_result_upd  = s.upd;
	assign o_result_chan = s.upd_chan;

	AST_SWRST_DEFAULTS:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(bus.wr_stb && bus.ptr == PTR_DEV_SETUP && bus.wdata[DEV_SWRST_BIT])
		|=> (s.conv == CONV_SETUP_RST && s.dly == 8'h0 && !s.range && s.st == SQ_IDLE))
	else $error("software reset left a register off its default");

	AST_SWRST_READS_ZERO:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(bus.wr_stb && bus.ptr == PTR_DEV_SETUP && bus.wdata[DEV_SWRST_BIT])
		|=> (bus.rdata == DEV_SETUP_RST))
	else $error("software reset bit read back as one");

	AST_START_DELAY:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.pend && s.dly != 8'h0 && s.conv[MODE_LSB +: 3] != 3'h0 && !bus.wr_stb)
		|=> (s.st == SQ_WAIT && s.cnt == 32'($past(s.dly)) * 32'(DLY_STEP_CYC) - 32'h1))
	else $error("start delay not loaded as code times step");

	AST_RANGE_FOLLOWS:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(bus.wr_stb && bus.ptr == PTR_DEV_SETUP && !bus.wdata[DEV_SWRST_BIT])
		|=> (o_shunt_range == $past(bus.wdata[DEV_RANGE_BIT])))
	else $error("range output does not follow the written bit");

	AST_RESERVED_ZERO:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(bus.ptr == PTR_DEV_SETUP) |-> ((bus.rdata & DEV_RSVD_MASK) == 16'h0000))
	else $error("reserved setup bits read nonzero");

	AST_SHUTDOWN_IDLE:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.pend && s.conv[MODE_LSB +: 3] == 3'h0 && !bus.wr_stb)
		|=> (!o_conv_active)[*3])
	else $error("converter ran in shutdown mode");

	AST_SINGLE_SHOT_STOPS:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.st == SQ_CONV && s.cnt == 32'h0 && s.samp == 11'h0 && (s.rem & ~s.chan) == 3'h0
		 && !s.conv[MODE_CONT_BIT] && !s.pend && !bus.wr_stb)
		|=> (s.st == SQ_IDLE && o_result_upd))
	else $error("single-shot set did not end after its last channel");

	AST_CONTINUOUS_REPEATS:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.st == SQ_CONV && s.cnt == 32'h0 && s.samp == 11'h0 && (s.rem & ~s.chan) == 3'h0
		 && s.conv[MODE_CONT_BIT] && !s.pend && !bus.wr_stb)
		|=> (s.st == SQ_CONV && s.rem == $past(s.conv[MODE_LSB +: 3])))
	else $error("continuous set did not restart");

	AST_CHANNEL_TIME:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.st == SQ_CONV && $changed(s.chan) && s.chan != 3'h0 && !$past(bus.wr_stb))
		|-> (s.cnt == ch_cyc(s.conv, s.chan) - 32'h1 && $onehot(s.chan)))
	else $error("channel started with the wrong conversion time");

	AST_AVG_UPDATE:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_result_upd |-> ($past(s.samp) == 11'h0 && $past(s.cnt) == 32'h0))
	else $error("result updated before averaging finished");
endmodule : power_monitor_conv_setup

// ===== pwrmon_pkg.sv
// constants, types and helpers shared by the converter setup block
package pwrmon_pkg;
	localparam int CLK_MHZ      = 50;
	localparam int DLY_STEP_MS  = 2;
	localparam int DLY_STEP_CYC = DLY_STEP_MS * 1000 * CLK_MHZ;

	localparam logic [7:0]  PTR_DEV_SETUP  = 8'h00;
	localparam logic [7:0]  PTR_CONV_SETUP = 8'h01;
	localparam logic [15:0] DEV_SETUP_RST  = 16'h0000;
	localparam logic [15:0] CONV_SETUP_RST = 16'hfb68;
	localparam logic [15:0] DEV_RSVD_MASK  = 16'h402f;

	localparam int DEV_SWRST_BIT = 15;
	localparam int DEV_DLY_LSB   = 6;
	localparam int DEV_RANGE_BIT = 4;
	localparam int MODE_LSB      = 12;
	localparam int MODE_CONT_BIT = 15;
	localparam int BUS_CT_LSB    = 9;
	localparam int SHUNT_CT_LSB  = 6;
	localparam int TEMP_CT_LSB   = 3;
	localparam int AVG_LSB       = 0;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b001,
		SQ_WAIT = 3'b010,
		SQ_CONV = 3'b100
	} seq_state_type;

	typedef enum logic [4:0] {
		I2_IDLE = 5'b00001,
		I2_RX   = 5'b00010,
		I2_ACKO = 5'b00100,
		I2_TX   = 5'b01000,
		I2_ACKI = 5'b10000
	} i2c_state_type;

	// conversion time in microseconds per code
	function automatic logic [12:0] conv_us(input logic [2:0] code);
		unique case (code)
			3'h0: conv_us = 13'd50;
			3'h1: conv_us = 13'd84;
			3'h2: conv_us = 13'd150;
			3'h3: conv_us = 13'd280;
			3'h4: conv_us = 13'd540;
			3'h5: conv_us = 13'd1052;
			3'h6: conv_us = 13'd2074;
			default: conv_us = 13'd4120;
		endcase
	endfunction : conv_us

	// samples averaged per code
	function automatic logic [10:0] avg_n(input logic [2:0] code);
		unique case (code)
			3'h0: avg_n = 11'd1;
			3'h1: avg_n = 11'd4;
			3'h2: avg_n = 11'd16;
			3'h3: avg_n = 11'd64;
			3'h4: avg_n = 11'd128;
			3'h5: avg_n = 11'd256;
			3'h6: avg_n = 11'd512;
			default: avg_n = 11'd1024;
		endcase
	endfunction : avg_n
endpackage : pwrmon_pkg

// ===== regbus_if.sv
// register access link between the serial slave and the register core
`timescale 1ns/100ps
interface regbus_if;
	logic        wr_stb;
	logic [7:0]  ptr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport slave_end (output wr_stb, output ptr, output wdata, input rdata);
	modport reg_end   (input wr_stb, input ptr, input wdata, output rdata);
endinterface : regbus_if

// ===== i2c_reg_slave.sv
// serial two-wire slave giving word access to the setup registers
`timescale 1ns/100ps
module i2c_reg_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_arst_n,
	// serial pins
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda_oe,
	// register side
	regbus_if.slave_end bus
);
	import pwrmon_pkg::*;

	typedef struct packed {
		i2c_state_type st;
		logic          scl_q;
		logic          sda_q;
		logic [7:0]    sh;
		logic [3:0]    bitc;
		logic [2:0]    bytec;
		logic          rnw;
		logic [7:0]    ptr;
		logic [7:0]    hi;
		logic [15:0]   txw;
		logic          oe;
		logic          wr;
		logic [15:0]   wdata;
	} slv_type;

	localparam slv_type SLV_RST = '{st: I2_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};

	slv_type s;
	slv_type nxt_s;
	logic    sclr;
	logic    sclf;
	logic    start_c;
	logic    stop_c;

	assign sclr    = i_scl & ~s.scl_q;
	assign sclf    = ~i_scl & s.scl_q;
	assign start_c = s.scl_q & i_scl & s.sda_q & ~i_sda;
	assign stop_c  = s.scl_q & i_scl & ~s.sda_q & i_sda;

	always_comb
	begin
		nxt_s       = s;
		nxt_s.scl_q = i_scl;
		nxt_s.sda_q = i_sda;
		nxt_s.wr    = 1'b0;
		if (start_c)
		begin
			nxt_s.st    = I2_RX;
			nxt_s.bitc  = 4'h0;
			nxt_s.bytec = 3'h0;
			nxt_s.oe    = 1'b0;
		end
		else if (stop_c)
		begin
			nxt_s.st = I2_IDLE;
			nxt_s.oe = 1'b0;
		end
		else
		begin
			unique case (s.st)
				I2_IDLE: ;
				I2_RX:
					if (sclr)
					begin
						nxt_s.sh   = {s.sh[6:0], i_sda};
						nxt_s.bitc = s.bitc + 4'h1;
					end
					else if (sclf && s.bitc == 4'h8)
					begin
						nxt_s.bitc = 4'h0;
						nxt_s.st   = I2_ACKO;
						nxt_s.oe   = 1'b1;
						// pointer byte, then high byte, then low byte
						unique case (s.bytec)
							3'h0:
								if (s.sh[7:1] == DEV_ADDR)
									nxt_s.rnw = s.sh[0];
								else
								begin
									nxt_s.st = I2_IDLE;
									nxt_s.oe = 1'b0;
								end
							3'h1: nxt_s.ptr = s.sh;
							3'h2: nxt_s.hi  = s.sh;
							3'h3:
							begin
								nxt_s.wr    = 1'b1;
								nxt_s.wdata = {s.hi, s.sh};
							end
							default: ;
						endcase
					end
				I2_ACKO:
					if (sclf)
					begin
						nxt_s.oe    = 1'b0;
						nxt_s.st    = I2_RX;
						nxt_s.bytec = (s.bytec == 3'h4) ? s.bytec : s.bytec + 3'h1;
						if (s.rnw && s.bytec == 3'h0)
						begin
							nxt_s.txw = bus.rdata;
							nxt_s.st  = I2_TX;
							nxt_s.oe  = ~bus.rdata[15];
						end
					end
				I2_TX:
					if (sclf)
					begin
						nxt_s.txw  = {s.txw[14:0], 1'b0};
						nxt_s.bitc = s.bitc + 4'h1;
						nxt_s.oe   = ~s.txw[14];
						if (s.bitc == 4'h7)
						begin
							nxt_s.oe   = 1'b0;
							nxt_s.st   = I2_ACKI;
							nxt_s.bitc = 4'h0;
						end
					end
				I2_ACKI:
					if (sclr && i_sda)
						nxt_s.st = I2_IDLE;
					else if (sclf)
					begin
						nxt_s.st = I2_TX;
						nxt_s.oe = ~s.txw[15];
					end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= SLV_RST;
		else
			s <= nxt_s;
	end

	assign o_sda_oe  = s.oe;
	assign bus.wr_stb = s.wr;
	assign bus.ptr    = s.ptr;
	assign bus.wdata  = s.wdata;

	AST_MSB_FIRST:
	assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(s.st == I2_ACKO && sclf && !start_c && s.rnw && s.bytec == 3'h0)
		|=> (s.st == I2_TX && s.oe == ~$past(bus.rdata[15])))
	else $error("read word does not start with its most significant bit");
endmodule : i2c_reg_slave

// ===== i2c_host_model.sv
// two-wire host model driving the serial pins of the converter setup block
`timescale 1ns/100ps
module i2c_host_model (
	// clock and serial line level
	input  wire logic i_ref_clk,
	input  wire logic i_sda,
	// host drive, high releases the line to the pull-up
	output logic      o_scl,
	output logic      o_sda
);
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// four clocks a phase keeps scl above the sampling minimum
	task automatic half();
		repeat (4) @(negedge i_ref_clk);
	endtask : half

	// also serves as repeated start from scl low
	task automatic start();
		half();
		o_sda = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		o_sda = 1'b0;
		half();
		o_scl = 1'b0;
	endtask : start

	task automatic stop();
		half();
		o_sda = 1'b0;
		half();
		o_scl = 1'b1;
		half();
		o_sda = 1'b1;
		half();
	endtask : stop

	// sda moves only mid low phase, never beside an scl edge
	task automatic xbit(input logic b, output logic r);
		half();
		o_sda = b;
		half();
		o_scl = 1'b1;
		half();
		r = i_sda;
		o_scl = 1'b0;
	endtask : xbit

	task automatic xbyte(input logic [7:0] wb, input logic ack_in,
		output logic [7:0] rb, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xbit(wb[i], r);
			rb[i] = r;
		end
		xbit(ack_in, ack);
	endtask : xbyte
endmodule : i2c_host_model

// ===== tb_power_monitor_conv_setup.sv
// self-checking bench for the converter setup block
`timescale 1ns/100ps
module tb_power_monitor_conv_setup;
	import pwrmon_pkg::*;
	// short delay step so a full delay code stays cheap
	localparam int DLY = 10;
	logic        i_ref_clk = 1'b0;
	logic        i_arst_n  = 1'b0;
	logic        scl;
	logic        sda_rel;
	wire logic   sda_line;
	logic        o_sda_oe;
	logic        o_sda;
	logic        o_shunt_range;
	logic        o_conv_active;
	logic        o_result_upd;
	logic [2:0]  o_conv_chan;
	logic [2:0]  o_result_chan;
	logic [2:0]  q_ch [$];
	int          q_t [$];
	int          fail_count  = 0;
	int          comparisons = 0;
	int          t0;
	int          k;
	int          b;
	logic [7:0]  rb;
	logic        ack;
	logic [15:0] t_word [4] = '{16'h9e00, 16'ha080, 16'hc018, 16'h9202};
	int          t_gap [4]  = '{4120, 150, 280, 1344};

	// open-drain line with pull-up
	assign sda_line = sda_rel & ~o_sda_oe;
	always #10 i_ref_clk = ~i_ref_clk;

	power_monitor_conv_setup #(.US_CYC(1), .DLY_STEP_CYC(DLY), .DEV_ADDR(7'h40))
		i_power_monitor_conv_setup (
		.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda_line),
		.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_shunt_range(o_shunt_range),
		.o_conv_active(o_conv_active), .o_conv_chan(o_conv_chan),
		.o_result_upd(o_result_upd), .o_result_chan(o_result_chan));

	i2c_host_model i_i2c_host_model (.i_ref_clk(i_ref_clk), .i_sda(sda_line),
		.o_scl(scl), .o_sda(sda_rel));

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte({7'h40, 1'b0}, 1'b1, rb, ack);
		check("ack_addr", 16'(ack), 16'h0000);
		i_i2c_host_model.xbyte(ptr, 1'b1, rb, ack);
		i_i2c_host_model.xbyte(d[15:8], 1'b1, rb, ack);
		i_i2c_host_model.xbyte(d[7:0], 1'b1, rb, ack);
		check("ack_lsb", 16'(ack), 16'h0000);
		i_i2c_host_model.stop();
	endtask : wr

	task automatic rdchk(input string name, input logic [7:0] ptr, input logic [15:0] exp);
		logic [15:0] d;
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte({7'h40, 1'b0}, 1'b1, rb, ack);
		i_i2c_host_model.xbyte(ptr, 1'b1, rb, ack);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte({7'h40, 1'b1}, 1'b1, rb, ack);
		i_i2c_host_model.xbyte(8'hff, 1'b0, rb, ack);
		d[15:8] = rb;
		i_i2c_host_model.xbyte(8'hff, 1'b1, rb, ack);
		d[7:0] = rb;
		i_i2c_host_model.stop();
		check(name, d, exp);
	endtask : rdchk

	// gathers result pulses and their cycle numbers for a fixed span
	task automatic observe(input int n);
		q_ch.delete();
		q_t.delete();
		for (int c = 0; c < n; c++)
		begin
			@(negedge i_ref_clk);
			if (o_result_upd === 1'b1)
			begin
				q_ch.push_back(o_result_chan);
				q_t.push_back(c);
			end
		end
	endtask : observe

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (4) @(negedge i_ref_clk);
		i_arst_n = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		check("chan_after_rst", 16'(o_conv_chan), 16'h0001);
		check("sda_value", 16'(o_sda), 16'h0000);
		rdchk("dev_rst", 8'h00, 16'h0000);
		rdchk("conv_rst", 8'h01, 16'hfb68);
		wr(8'h00, 16'h7fff);
		rdchk("dev_rsvd", 8'h00, 16'h3fd0);
		check("range_narrow", 16'(o_shunt_range), 16'h0001);
		wr(8'h01, 16'h0a5b);
		rdchk("conv_rw", 8'h01, 16'h0a5b);
		wr(8'h02, 16'h1234);
		rdchk("unmapped", 8'h02, 16'h0000);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte({7'h41, 1'b0}, 1'b1, rb, ack);
		check("nack_addr", 16'(ack), 16'h0001);
		i_i2c_host_model.stop();
		wr(8'h00, 16'h8000);
		rdchk("dev_swrst", 8'h00, 16'h0000);
		rdchk("conv_swrst", 8'h01, 16'hfb68);
		check("range_swrst", 16'(o_shunt_range), 16'h0000);
		// every mode code with the shortest times, no averaging
		for (int m = 0; m < 16; m++)
		begin
			wr(8'h01, {m[3:0], 12'h000});
			observe(400);
			k = int'(m[0]) + int'(m[1]) + int'(m[2]);
			if (m[3] && k > 0)
				check("cont_count", 16'(q_ch.size() >= 6), 16'h0001);
			else
				check("shot_count", 16'(q_ch.size()), 16'(k));
			b = 0;
			for (int i = 0; i < q_ch.size(); i++)
			begin
				while (k > 0 && !m[b])
					b = (b + 1) % 3;
				check("upd_chan", 16'(q_ch[i]), 16'(1 << b));
				b = (b + 1) % 3;
				if (i > 0)
					check("gap_min", 16'(q_t[i] - q_t[i-1]), 16'h0032);
			end
			if (!m[3] || k == 0)
				check("idle_after", 16'(o_conv_active), 16'h0000);
		end
		// conversion time codes and averaging on one channel each
		for (int j = 0; j < 4; j++)
		begin
			wr(8'h01, t_word[j]);
			observe(3 * t_gap[j]);
			check("conv_gap", 16'(q_t[1] - q_t[0]), 16'(t_gap[j]));
		end
		// start delay measured against a zero-delay reference
		wr(8'h01, 16'h1000);
		observe(3000);
		t0 = q_t[0];
		wr(8'h00, 16'h0040);
		wr(8'h01, 16'h1000);
		observe(3000);
		check("dly_one", 16'(q_t[0] - t0), 16'(DLY));
		wr(8'h00, 16'h3fc0);
		wr(8'h01, 16'h1000);
		check("wait_idle", 16'(o_conv_active), 16'h0000);
		observe(3000);
		check("dly_max", 16'(q_t[0] - t0), 16'(255 * DLY));
		print_verdict();
	end
endmodule : tb_power_monitor_conv_setup
